// ---- core/isr_event_reg.sv ----
// Eight-bit sticky event register with per-bit enable gating.
// Assumes set, enable and clear come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module isr_event_reg
   import isr_pkg::*;
#(
   parameter logic [7:0] RST_VAL = 8'h00,
   parameter logic [7:0] USED = 8'hff
) (
   input wire logic mclk, // System clock
   input wire logic rstn, // Synchronous reset, active low
   input wire logic [7:0] setEv, // Event pulses per bit
   input wire logic [7:0] enable, // Enable mask per bit
   input wire logic clear, // Clear all bits
   output logic [7:0] evNext, // Next register value
   output logic [7:0] evQ // Latched event bits
);
   // ========================================================================
   // Per-bit latch, set wins over clear
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_bit
         assign evNext[i] = USED[i] &
            ((evQ[i] & ~clear) | (setEv[i] & enable[i]));
         always_ff @(posedge mclk) begin
            if (!rstn) begin
               evQ[i] <= RST_VAL[i];
            end else begin
               evQ[i] <= evNext[i];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ---- core/isr_pkg.sv ----
// Constants, command codes and bit positions of the status reporting core.
// Assumes one clock domain; included by the event register and the top.
// ===========================================================================
// Summary of operation
// - Event bits latch until explicitly cleared
// - Event query or clear-status clears event bits
// - Reset command leaves event bits unchanged
// - Event query returns all bits as one byte
// - Enables read/write; enable gates latching; reads harmless
// - Clear-status keeps every enable register intact
// - Status bit 4 follows output queue holding data
// - Clearing event register clears its summary bit
// - Status bits 0, 1, 7 read zero
// - Status bit 2 set while error queue nonempty
// - Status bit 3 summarises enabled questionable bits
// - Status bit 5 summarises enabled standard events
// - Bit 6 master summary raises service request
// - Clear-status or group read clears summary bits
// - Writing zero to service mask clears it
// - Status query returns current status byte
// - Completion bit set when overlapped operations finish
// - Query error bit set on three causes
// - Device, execution, syntax errors set bits 3-5
// - Power-on bit set after reset until read
// - Standard event bits 1 and 6 read zero
package isr_pkg;
   localparam int unsigned ISR_W = 8;

   // Command codes seen on the command port
   typedef enum logic [3:0] {
      ISR_CMD_CLS,
      ISR_CMD_ESR_Q,
      ISR_CMD_ESE_W,
      ISR_CMD_ESE_Q,
      ISR_CMD_SRE_W,
      ISR_CMD_SRE_Q,
      ISR_CMD_STB_Q,
      ISR_CMD_OPC,
      ISR_CMD_RST,
      ISR_CMD_QES_Q,
      ISR_CMD_QEE_W,
      ISR_CMD_QEE_Q
   } isr_cmd_e;

   // Standard event bit positions
   localparam int unsigned ESB_OPC = 0;
   localparam int unsigned ESB_QRY = 2;
   localparam int unsigned ESB_DEV = 3;
   localparam int unsigned ESB_EXE = 4;
   localparam int unsigned ESB_CMD = 5;
   localparam int unsigned ESB_PON = 7;
   localparam logic [7:0] ESR_USED = 8'hbd;
   localparam logic [7:0] ESR_RST = 8'h80;

   // Status byte bit positions
   localparam int unsigned SBB_ERQ = 2;
   localparam int unsigned SBB_QUE = 3;
   localparam int unsigned SBB_MAV = 4;
   localparam int unsigned SBB_ESB = 5;
   localparam int unsigned SBB_MSS = 6;
   localparam logic [7:0] SRE_MASK = 8'hbf;

   // Reset values of the enable registers and questionable events
   localparam logic [7:0] ENA_RST = 8'h00;
   localparam logic [7:0] QUE_RST = 8'h00;
endpackage

// ---- core/isr_status_core.sv ----
// Status reporting core: standard and questionable event registers, enables,
// status byte and service request, driven by common command strobes.
// Assumes the command parser and event sources share mclk.
`timescale 1ns/1ps
`default_nettype none
module isr_status_core
   import isr_pkg::*;
(
   input wire logic mclk, // 100 MHz clock
   input wire logic rstn, // Synchronous reset, active low
   input wire logic cmdValid, // Command strobe, one cycle
   input wire logic [3:0] cmdCode, // Command code
   input wire logic [7:0] cmdData, // Write value for mask commands
   input wire logic opPending, // Overlapped operations still running
   input wire logic errQueueEmptyRead, // Error queue read while empty
   input wire logic errQueueEarlyRead, // Queue read before new command
   input wire logic ioBufFull, // Input or output buffer full
   input wire logic devError, // Device-specific error pulse
   input wire logic execError, // Execution error pulse
   input wire logic syntaxError, // Command syntax error pulse
   input wire logic errQueueNotEmpty, // Error queue holds an entry
   input wire logic outQueueNotEmpty, // Output queue holds a message
   input wire logic [7:0] quesEvents, // Questionable condition pulses
   output logic respValid, // Query answer strobe
   output logic [7:0] respData, // Query answer value
   output logic [7:0] statusByte, // Current status byte
   output logic serviceReq // Service request
);
   // ========================================================================
   // Command decode
   logic isCls, isEsrQ, isEseW, isEseQ, isSreW, isSreQ, isStbQ;
   logic isOpc, isRst, isQesQ, isQeeW, isQeeQ;
   always_comb begin
      isCls = cmdValid && cmdCode == ISR_CMD_CLS;
      isEsrQ = cmdValid && cmdCode == ISR_CMD_ESR_Q;
      isEseW = cmdValid && cmdCode == ISR_CMD_ESE_W;
      isEseQ = cmdValid && cmdCode == ISR_CMD_ESE_Q;
      isSreW = cmdValid && cmdCode == ISR_CMD_SRE_W;
      isSreQ = cmdValid && cmdCode == ISR_CMD_SRE_Q;
      isStbQ = cmdValid && cmdCode == ISR_CMD_STB_Q;
      isOpc = cmdValid && cmdCode == ISR_CMD_OPC;
      isRst = cmdValid && cmdCode == ISR_CMD_RST;
      isQesQ = cmdValid && cmdCode == ISR_CMD_QES_Q;
      isQeeW = cmdValid && cmdCode == ISR_CMD_QEE_W;
      isQeeQ = cmdValid && cmdCode == ISR_CMD_QEE_Q;
   end

   // ========================================================================
   // Enable registers, written only by their own commands
   logic [7:0] eseQ, eseD, sreQ, sreD, qeeQ, qeeD;
   always_comb begin
      eseD = isEseW ? cmdData : eseQ;
      sreD = isSreW ? cmdData : sreQ;
      qeeD = isQeeW ? cmdData : qeeQ;
   end
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         eseQ <= ENA_RST;
         sreQ <= ENA_RST;
         qeeQ <= ENA_RST;
      end else begin
         eseQ <= eseD;
         sreQ <= sreD;
         qeeQ <= qeeD;
      end
   end

   // ========================================================================
   // Operation complete tracking after the completion command
   logic opcArmQ, opcDone;
   assign opcDone = opcArmQ && !opPending;
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         opcArmQ <= 1'b0;
      end else if (isOpc) begin
         opcArmQ <= 1'b1;
      end else if (opcDone) begin
         opcArmQ <= 1'b0;
      end
   end

   // ========================================================================
   // Standard event sources; power-on bit comes from the reset value
   logic [7:0] stdSet, esrNext, esrQ;
   logic esrClear;
   always_comb begin
      stdSet = 8'h00;
      stdSet[ESB_OPC] = opcDone;
      stdSet[ESB_QRY] = errQueueEmptyRead | errQueueEarlyRead |
         ioBufFull;
      stdSet[ESB_DEV] = devError;
      stdSet[ESB_EXE] = execError;
      stdSet[ESB_CMD] = syntaxError;
   end
   // The reset command is deliberately absent from the clear term
   assign esrClear = isCls | isEsrQ;

   isr_event_reg #(
      .RST_VAL(ESR_RST),
      .USED(ESR_USED)
   ) u_std (
      .mclk(mclk),
      .rstn(rstn),
      .setEv(stdSet),
      .enable(eseD),
      .clear(esrClear),
      .evNext(esrNext),
      .evQ(esrQ)
   );

   // ========================================================================
   // Questionable event register
   logic [7:0] quesNext, quesQ;
   logic quesClear;
   assign quesClear = isCls | isQesQ;

   isr_event_reg #(
      .RST_VAL(QUE_RST),
      .USED(8'hff)
   ) u_ques (
      .mclk(mclk),
      .rstn(rstn),
      .setEv(quesEvents),
      .enable(qeeD),
      .clear(quesClear),
      .evNext(quesNext),
      .evQ(quesQ)
   );

   // ========================================================================
   // Status byte built from next-state values so it moves with its causes
   logic [7:0] stbD;
   logic mssD;
   always_comb begin
      stbD = 8'h00;
      stbD[SBB_ERQ] = errQueueNotEmpty;
      stbD[SBB_QUE] = |(quesNext & qeeD);
      stbD[SBB_MAV] = outQueueNotEmpty;
      stbD[SBB_ESB] = |(esrNext & eseD);
      mssD = |(stbD & sreD & SRE_MASK);
      stbD[SBB_MSS] = mssD;
   end

   // Status byte and service request outputs
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         statusByte <= 8'h00;
         serviceReq <= 1'b0;
      end else begin
         statusByte <= stbD;
         serviceReq <= mssD;
      end
   end

   // ========================================================================
   // Query answers, one cycle after the command; reads of enables are pure
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         respValid <= 1'b0;
         respData <= 8'h00;
      end else begin
         respValid <= isEsrQ | isEseQ | isSreQ | isStbQ | isQesQ | isQeeQ;
         if (isEsrQ) begin
            respData <= esrQ;
         end else if (isQesQ) begin
            respData <= quesQ;
         end else if (isEseQ) begin
            respData <= eseQ;
         end else if (isSreQ) begin
            respData <= sreQ;
         end else if (isQeeQ) begin
            respData <= qeeQ;
         end else if (isStbQ) begin
            respData <= statusByte;
         end
      end
   end

   // ========================================================================
   // Assertions
   logic stdQuiet;
   assign stdQuiet = stdSet == 8'h00;

   property p_esrClear;
      @(posedge mclk) disable iff (!rstn)
      (esrClear && stdQuiet) |=> esrQ == 8'h00;
   endproperty
   a_esrClear: assert property (p_esrClear)
      else $error("event bits survived a clear");

   property p_latch;
      @(posedge mclk) disable iff (!rstn)
      (!esrClear && esrQ[ESB_DEV]) |=> esrQ[ESB_DEV];
   endproperty
   a_latch: assert property (p_latch)
      else $error("latched event bit dropped");

   property p_rstKeep;
      @(posedge mclk) disable iff (!rstn)
      (isRst && stdQuiet) |=> $stable(esrQ);
   endproperty
   a_rstKeep: assert property (p_rstKeep)
      else $error("reset command changed event bits");

   property p_esrAnswer;
      @(posedge mclk) disable iff (!rstn)
      isEsrQ |=> respValid && respData == $past(esrQ);
   endproperty
   a_esrAnswer: assert property (p_esrAnswer)
      else $error("event query answer wrong");

   property p_enRead;
      @(posedge mclk) disable iff (!rstn)
      (isEseQ || isCls) |=> $stable(eseQ) && $stable(sreQ);
   endproperty
   a_enRead: assert property (p_enRead)
      else $error("enable register changed without write");

   property p_gate;
      @(posedge mclk) disable iff (!rstn)
      (!eseD[ESB_EXE] && !esrQ[ESB_EXE]) |=> !esrQ[ESB_EXE];
   endproperty
   a_gate: assert property (p_gate)
      else $error("disabled event bit latched");

   property p_mav;
      @(posedge mclk) disable iff (!rstn)
      ##1 statusByte[SBB_MAV] == $past(outQueueNotEmpty);
   endproperty
   a_mav: assert property (p_mav)
      else $error("message available bit wrong");

   property p_unused;
      @(posedge mclk) disable iff (!rstn)
      statusByte[0] == 1'b0 && statusByte[1] == 1'b0 &&
         statusByte[7] == 1'b0 && esrQ[1] == 1'b0 && esrQ[6] == 1'b0;
   endproperty
   a_unused: assert property (p_unused)
      else $error("unused bit reads one");

   property p_sum;
      @(posedge mclk) disable iff (!rstn)
      statusByte[SBB_ESB] == |(esrQ & eseQ) &&
         statusByte[SBB_QUE] == |(quesQ & qeeQ);
   endproperty
   a_sum: assert property (p_sum)
      else $error("summary bit out of step");

   property p_srq;
      @(posedge mclk) disable iff (!rstn)
      serviceReq == statusByte[SBB_MSS] &&
         serviceReq == |(statusByte & sreQ & SRE_MASK);
   endproperty
   a_srq: assert property (p_srq)
      else $error("service request differs from master summary");

   property p_sreZero;
      @(posedge mclk) disable iff (!rstn)
      (isSreW && cmdData == 8'h00) |=> sreQ == 8'h00 && !serviceReq;
   endproperty
   a_sreZero: assert property (p_sreZero)
      else $error("service mask not cleared");

   property p_erq;
      @(posedge mclk) disable iff (!rstn)
      ##1 statusByte[SBB_ERQ] == $past(errQueueNotEmpty);
   endproperty
   a_erq: assert property (p_erq)
      else $error("error queue bit wrong");

   property p_stbAnswer;
      @(posedge mclk) disable iff (!rstn)
      isStbQ |=> respValid && respData == $past(statusByte);
   endproperty
   a_stbAnswer: assert property (p_stbAnswer)
      else $error("status query answer wrong");

   property p_clsStb;
      @(posedge mclk) disable iff (!rstn)
      (isCls && stdQuiet && quesEvents == 8'h00) |=>
         !statusByte[SBB_ESB] && !statusByte[SBB_QUE];
   endproperty
   a_clsStb: assert property (p_clsStb)
      else $error("clear status left a summary bit");

   property p_quesRead;
      @(posedge mclk) disable iff (!rstn)
      (isQesQ && stdQuiet && quesEvents == 8'h00) |=>
         !statusByte[SBB_QUE] && $stable(esrQ);
   endproperty
   a_quesRead: assert property (p_quesRead)
      else $error("questionable read cleared the wrong group");

   sequence s_opcCmd;
      isOpc && eseQ[ESB_OPC] && !isEseW && !esrClear;
   endsequence
   sequence s_opcQuiet;
      (!opPending && !esrClear && !isEseW) [*2];
   endsequence
   property p_opc;
      @(posedge mclk) disable iff (!rstn)
      s_opcCmd ##1 s_opcQuiet |=> esrQ[ESB_OPC];
   endproperty
   a_opc: assert property (p_opc)
      else $error("operation complete bit not set");
endmodule
`default_nettype wire

// ---- dv/instrument_status_reporting_bench.sv ----
// Self-checking bench for the status reporting core.
// Assumes the controller model drives the command port.
`timescale 1ns/1ps
`default_nettype none
module instrument_status_reporting_bench;
   import isr_pkg::*;
   logic mclk = 1'b0, rstn = 1'b0, opPending = 1'b0;
   logic errQueueNotEmpty = 1'b0, outQueueNotEmpty = 1'b0;
   logic [5:0] evIn = 6'h00;
   logic [7:0] quesIn = 8'h00;
   logic cmdValid, respValid, serviceReq;
   logic [3:0] cmdCode;
   logic [7:0] cmdData, respData, statusByte;
   int errTotal = 0, testsRun = 0;

   // ========================================================================
   // Clock and instances
   always #5 mclk = ~mclk;
   isr_ctrl_model ctrl_u (.mclk(mclk), .cmdValid(cmdValid),
      .cmdCode(cmdCode), .cmdData(cmdData));
   isr_status_core dut_u (.mclk(mclk), .rstn(rstn), .cmdValid(cmdValid),
      .cmdCode(cmdCode), .cmdData(cmdData), .opPending(opPending),
      .errQueueEmptyRead(evIn[5]), .errQueueEarlyRead(evIn[4]),
      .ioBufFull(evIn[3]), .devError(evIn[2]), .execError(evIn[1]),
      .syntaxError(evIn[0]), .errQueueNotEmpty(errQueueNotEmpty),
      .outQueueNotEmpty(outQueueNotEmpty), .quesEvents(quesIn),
      .respValid(respValid), .respData(respData),
      .statusByte(statusByte), .serviceReq(serviceReq));

   // ========================================================================
   // Compare helpers
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      testsRun++;
      if (got !== exp) begin
         errTotal++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      testsRun++;
      if (got !== exp) begin
         errTotal++;
         $display("unexpected at %0t: flag %b want %b", $time, got, exp);
      end
   endtask
   // Query and judge the answer strobe and value
   task automatic qry(input isr_cmd_e c, input logic [7:0] exp);
      ctrl_u.send(c, 8'h00);
      chk1(respValid, 1'b1);
      chk8(respData, exp);
   endtask
   // One-cycle pulse on event inputs
   task automatic pulse(input logic [5:0] v, input logic [7:0] q);
      @(negedge mclk);
      evIn = v;
      quesIn = q;
      @(negedge mclk);
      evIn = 6'h00;
      quesIn = 8'h00;
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // ========================================================================
   // Scenarios
   task automatic t_reset;
      chk8(statusByte, 8'h00);
      qry(ISR_CMD_ESR_Q, 8'h80);
      qry(ISR_CMD_ESR_Q, 8'h00);
   endtask
   task automatic t_errors;
      pulse(6'h04, 8'h00);
      qry(ISR_CMD_ESR_Q, 8'h00);
      ctrl_u.send(ISR_CMD_ESE_W, 8'hff);
      ctrl_u.send(ISR_CMD_SRE_W, 8'h20);
      pulse(6'h20, 8'h00);
      pulse(6'h10, 8'h00);
      pulse(6'h08, 8'h00);
      pulse(6'h07, 8'h00);
      wait_n(3);
      chk8(statusByte, 8'h60);
      chk1(serviceReq, 1'b1);
      ctrl_u.send(ISR_CMD_RST, 8'h00);
      qry(ISR_CMD_STB_Q, 8'h60);
      qry(ISR_CMD_ESE_Q, 8'hff);
      qry(ISR_CMD_ESR_Q, 8'h3c);
      chk8(statusByte, 8'h00);
      chk1(serviceReq, 1'b0);
   endtask
   task automatic t_clear;
      pulse(6'h02, 8'h00);
      chk8(statusByte, 8'h60);
      wait_n(4);
      chk8(statusByte, 8'h60);
      ctrl_u.send(ISR_CMD_CLS, 8'h00);
      chk8(statusByte, 8'h00);
      qry(ISR_CMD_ESE_Q, 8'hff);
      qry(ISR_CMD_SRE_Q, 8'h20);
      ctrl_u.send(ISR_CMD_SRE_W, 8'h00);
      qry(ISR_CMD_SRE_Q, 8'h00);
   endtask
   task automatic t_opc;
      opPending = 1'b1;
      ctrl_u.send(ISR_CMD_OPC, 8'h00);
      wait_n(3);
      chk8(statusByte, 8'h00);
      opPending = 1'b0;
      wait_n(2);
      chk8(statusByte, 8'h20);
      qry(ISR_CMD_ESR_Q, 8'h01);
      // Completion with nothing pending sets the bit one cycle after the command
      ctrl_u.send(ISR_CMD_OPC, 8'h00);
      wait_n(2);
      chk8(statusByte, 8'h20);
      qry(ISR_CMD_ESR_Q, 8'h01);
   endtask
   task automatic t_queues;
      errQueueNotEmpty = 1'b1;
      outQueueNotEmpty = 1'b1;
      wait_n(2);
      chk8(statusByte, 8'h14);
      ctrl_u.send(ISR_CMD_SRE_W, 8'h10);
      wait_n(1);
      chk8(statusByte, 8'h54);
      outQueueNotEmpty = 1'b0;
      errQueueNotEmpty = 1'b0;
      wait_n(2);
      chk8(statusByte, 8'h00);
      chk1(serviceReq, 1'b0);
   endtask
   task automatic t_ques;
      ctrl_u.send(ISR_CMD_QEE_W, 8'h01);
      pulse(6'h00, 8'h02);
      chk8(statusByte, 8'h00);
      pulse(6'h00, 8'h01);
      chk8(statusByte, 8'h08);
      qry(ISR_CMD_QES_Q, 8'h01);
      chk8(statusByte, 8'h00);
      qry(ISR_CMD_QEE_Q, 8'h01);
   endtask
   // Second reset in mid-run brings back the power-on bit
   task automatic t_rerun;
      rstn = 1'b0;
      wait_n(2);
      rstn = 1'b1;
      chk8(statusByte, 8'h00);
      qry(ISR_CMD_ESE_Q, 8'h00);
      qry(ISR_CMD_ESR_Q, 8'h80);
   endtask

   // ========================================================================
   // Verdict and end of run
   task automatic completeRun;
      $display("checks %0d, mismatches %0d", testsRun, errTotal);
      if (errTotal == 0 && testsRun > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (6) @(negedge mclk);
      rstn = 1'b1;
      t_reset();
      t_errors();
      t_clear();
      t_opc();
      t_queues();
      t_ques();
      t_rerun();
      completeRun();
   end

   // Watchdog: whole run needs under a hundred cycles
   initial begin
      #50us;
      errTotal++;
      $display("unexpected at %0t: watchdog expired", $time);
      completeRun();
   end
endmodule
`default_nettype wire

// ---- dv/isr_ctrl_model.sv ----
// Remote controller model issuing common commands to the status core.
// Assumes the core samples commands on the rising edge of mclk.
`timescale 1ns/1ps
`default_nettype none
module isr_ctrl_model
   import isr_pkg::*;
(
   input wire logic mclk, // System clock
   output logic cmdValid, // Command strobe
   output logic [3:0] cmdCode, // Command code
   output logic [7:0] cmdData // Write value
);
   // ========================================================================
   // Idle state: lines show garbage, never the last command
   initial begin
      cmdValid = 1'b0;
      cmdCode = 4'hf;
      cmdData = 8'h5a;
   end

   // One command cycle; idle lines invert so stale values never match
   task automatic send(input isr_cmd_e code, input logic [7:0] data);
      @(negedge mclk);
      cmdValid = 1'b1;
      cmdCode = code;
      cmdData = data;
      @(negedge mclk);
      cmdValid = 1'b0;
      cmdCode = ~cmdCode;
      cmdData = ~cmdData;
   endtask
endmodule
`default_nettype wire
